// file: verilog/ppr_defines.svh
// Constants of the peripheral pin remap block.
// How it works
// - Up to 26 remappable pins, count parameterised.
// - Any peripheral I/O reaches any pool pin.
// - Separate input and output mapping register groups.
// - Input and output routing never constrain each other.
// - Hardware protection guards established mapping.
// - Inputs selected per peripheral, outputs per pin.
// - Five-bit selector per peripheral input.
// - Two five-bit output selectors per word.
// - Unused output register bits read zero.
`ifndef PPR_DEFINES_SVH
`define PPR_DEFINES_SVH
`define PPR_MAX_PINS 26
`define PPR_SEL_W 5
`define PPR_REG_W 16
`define PPR_LO_LSB 0
`define PPR_HI_LSB 8
`define PPR_SEL_RESET 5'h00
`define PPR_LOCK_RESET 1'b0
`endif

// file: verilog/ppr_pkg.sv
// Types shared by the peripheral pin remap block.
`default_nettype none
package ppr_pkg;
  typedef struct packed {
    logic        inWrite;
    logic        outWrite;
    logic [4:0]  index;
    logic [15:0] data;
  } ppr_cfg_wr_t;
endpackage
`default_nettype wire

// file: verilog/ppr_sel_mux.sv
// One selector-driven multiplexer of the remap fabric.
`include "ppr_defines.svh"
`default_nettype none
module ppr_sel_mux
  import ppr_pkg::*;
#(
  parameter int WIDTH = 26
) (
  input  wire logic [WIDTH-1:0] candidates,
  input  wire logic [4:0]       sel,
  output logic                  chosen
);
  // Codes beyond the pool give a low level.
  always_comb begin
    chosen = 1'b0;
    if (int'(sel) < WIDTH) begin
      chosen = candidates[sel];
    end
  end
endmodule // ppr_sel_mux
`default_nettype wire

// file: verilog/ppr_remap.sv
// Peripheral pin remap top with both mapping register groups.
`include "ppr_defines.svh"
`default_nettype none
module ppr_remap
  import ppr_pkg::*;
#(
  parameter int NUM_PINS  = `PPR_MAX_PINS,
  parameter int NUM_PIN_IN = 25,
  parameter int NUM_FUNCS = 31
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire ppr_cfg_wr_t           cfgWr,
  input  wire logic                  lockSet,
  input  wire logic                  lockClear,
  input  wire logic [4:0]            rdIndex,
  output logic [15:0]                inRdData,
  output logic [15:0]                outRdData,
  output logic                       locked,
  input  wire logic [NUM_PINS-1:0]   pinIn,
  output logic [NUM_PIN_IN-1:0]      periphIn,
  input  wire logic [NUM_FUNCS:1]    periphOut,
  output logic [NUM_PINS-1:0]        pinOut,
  output logic [NUM_PINS-1:0]        pinOutEn
);
  localparam int OUT_REGS = (NUM_PINS + 1) / 2;

  // =========================================================
  // Register state
  logic [4:0]          inSel_reg  [NUM_PIN_IN];
  logic [4:0]          outSel_reg [2*OUT_REGS];
  logic                lock_reg;
  logic [NUM_PINS-1:0] pinS1_reg;
  logic [NUM_PINS-1:0] pinS2_reg;
  logic [NUM_PINS-1:0] pinS3_reg;
  logic [NUM_PINS-1:0] pinClean_reg;

  // =========================================================
  // Lock flag
  // lock flag control
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_reg <= `PPR_LOCK_RESET;
    end else if (lockSet) begin
      lock_reg <= 1'b1;
    end else if (lockClear) begin
      lock_reg <= 1'b0;
    end
  end
  assign locked = lock_reg;

  // =========================================================
  // Input mapping group
  // per-input selectors
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_PIN_IN; i++) begin
        inSel_reg[i] <= `PPR_SEL_RESET;
      end
    end else if (cfgWr.inWrite && !lock_reg &&
                 int'(cfgWr.index) < NUM_PIN_IN) begin
      inSel_reg[cfgWr.index] <= cfgWr.data[`PPR_SEL_W-1:0];
    end
  end

  // =========================================================
  // Output mapping group
  // paired output selectors
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 2*OUT_REGS; i++) begin
        outSel_reg[i] <= `PPR_SEL_RESET;
      end
    end else if (cfgWr.outWrite && !lock_reg &&
                 int'(cfgWr.index) < OUT_REGS) begin
      outSel_reg[2*cfgWr.index] <=
        cfgWr.data[`PPR_LO_LSB +: `PPR_SEL_W];
      outSel_reg[2*cfgWr.index+1] <=
        cfgWr.data[`PPR_HI_LSB +: `PPR_SEL_W];
    end
  end

  // =========================================================
  // Readback
  // unused bits read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      inRdData  <= 16'h0000;
      outRdData <= 16'h0000;
    end else begin
      inRdData  <= 16'h0000;
      outRdData <= 16'h0000;
      if (int'(rdIndex) < NUM_PIN_IN) begin
        inRdData[4:0] <= inSel_reg[rdIndex];
      end
      if (int'(rdIndex) < OUT_REGS) begin
        outRdData[`PPR_LO_LSB +: `PPR_SEL_W] <= outSel_reg[2*rdIndex];
        outRdData[`PPR_HI_LSB +: `PPR_SEL_W] <= outSel_reg[2*rdIndex+1];
      end
    end
  end

  // =========================================================
  // Pin input synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      pinS1_reg    <= '0;
      pinS2_reg    <= '0;
      pinS3_reg    <= '0;
      pinClean_reg <= '0;
    end else begin
      pinS1_reg <= pinIn;
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pinS2_reg[i] == pinS3_reg[i]) begin
          pinClean_reg[i] <= pinS3_reg[i];
        end
      end
    end
  end

  // =========================================================
  // Routing fabric
  // independent input routing
  for (genvar g = 0; g < NUM_PIN_IN; g++) begin : gIn
    ppr_sel_mux #(.WIDTH(NUM_PINS)) uMux (
      .candidates (pinClean_reg),
      .sel        (inSel_reg[g]),
      .chosen     (periphIn[g])
    );
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : gOut
    logic [NUM_FUNCS:0] funcs;
    logic               drive;
    assign funcs = {periphOut, 1'b0};
    always_ff @(posedge clock) begin
      if (rst) begin
        pinOut[p]   <= 1'b0;
        pinOutEn[p] <= 1'b0;
      end else begin
        pinOut[p]   <= drive;
        pinOutEn[p] <= (outSel_reg[p] != 5'h00) &&
                       (int'(outSel_reg[p]) <= NUM_FUNCS);
      end
    end
    ppr_sel_mux #(.WIDTH(NUM_FUNCS+1)) uMux (
      .candidates (funcs),
      .sel        (outSel_reg[p]),
      .chosen     (drive)
    );
  end

  // =========================================================
  // Assertions
  AST_LOCK_HOLDS_IN: assert property (@(posedge clock) disable iff (rst)
    (lock_reg && !lockClear) |=> $stable(inSel_reg[0]))
    else $error("Input selector changed while locked.");
  AST_LOCK_HOLDS_OUT: assert property (@(posedge clock) disable iff (rst)
    (lock_reg && !lockClear) |=> $stable(outSel_reg[0]))
    else $error("Output selector changed while locked.");
  AST_IN_WRITE: assert property (@(posedge clock) disable iff (rst)
    (cfgWr.inWrite && !lock_reg && cfgWr.index == 5'h00)
    |=> inSel_reg[0] == $past(cfgWr.data[4:0]))
    else $error("Input selector write lost.");
  AST_OUT_WRITE: assert property (@(posedge clock) disable iff (rst)
    (cfgWr.outWrite && !lock_reg && cfgWr.index == 5'h00)
    |=> outSel_reg[1] == $past(cfgWr.data[12:8]))
    else $error("Upper output selector write lost.");
  AST_ZERO_BITS: assert property (@(posedge clock) disable iff (rst)
    outRdData[15:13] == 3'h0 && outRdData[7:5] == 3'h0)
    else $error("Unused output bits not zero.");
  AST_OUT_IDLE: assert property (@(posedge clock) disable iff (rst)
    (outSel_reg[0] == 5'h00) |=> !pinOutEn[0])
    else $error("Unassigned pin driven.");
  AST_IN_ROUTE: assert property (@(posedge clock) disable iff (rst)
    (inSel_reg[0] == 5'h01 && $stable(inSel_reg[0]))
    |-> periphIn[0] == pinClean_reg[1])
    else $error("Input route wrong.");
  AST_SEPARATE: assert property (@(posedge clock) disable iff (rst)
    (cfgWr.inWrite && !cfgWr.outWrite) |=> $stable(outSel_reg[0]))
    else $error("Input write disturbed output map.");
  COV_LOCKED_WRITE: cover property (@(posedge clock)
    lock_reg && cfgWr.inWrite);
  COV_OUT_DRIVE: cover property (@(posedge clock) pinOutEn[0]);
  COV_UNLOCK: cover property (@(posedge clock) lock_reg && lockClear);
endmodule // ppr_remap
`default_nettype wire

// file: dv/ppr_far_model.sv
// Far-side model of remappable pins and peripheral outputs.
`default_nettype none
module ppr_far_model (
  input  wire logic        clock,
  input  wire logic [4:0]  drivePin,
  output logic      [25:0] pinIn,
  output logic      [31:1] periphOut
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock) pinIn <= 26'h1 << drivePin;
  always_comb begin
    for (int n = 1; n < 32; n++) periphOut[n] = n[0];
  end
endmodule // ppr_far_model
`default_nettype wire

// file: dv/ppr_remap_bench.sv
// Self-checking bench of the peripheral pin remap block.
`default_nettype none
module ppr_remap_bench import ppr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================
  // Signals and instances.
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        lockSet = 1'b0;
  logic        lockClear = 1'b0;
  ppr_cfg_wr_t cfgWr = '0;
  logic [4:0]  rdIndex = 5'h00;
  logic [4:0]  drivePin = 5'h00;
  logic [15:0] inRdData;
  logic [15:0] outRdData;
  logic        locked;
  logic [25:0] pinIn;
  logic [25:0] pinOut;
  logic [25:0] pinOutEn;
  logic [24:0] periphIn;
  logic [31:1] periphOut;
  int          errCount = 0;
  int          checked = 0;
  always #2 clock = ~clock;
  ppr_remap uut (.clock(clock), .rst(rst), .cfgWr(cfgWr),
    .lockSet(lockSet), .lockClear(lockClear), .rdIndex(rdIndex),
    .inRdData(inRdData), .outRdData(outRdData), .locked(locked),
    .pinIn(pinIn), .periphIn(periphIn), .periphOut(periphOut),
    .pinOut(pinOut), .pinOutEn(pinOutEn));
  ppr_far_model far (.clock(clock), .drivePin(drivePin),
    .pinIn(pinIn), .periphOut(periphOut));
  // ====================================================
  // Shared tasks.
  task automatic cmp(input logic [25:0] got, input logic [25:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic inW, input logic [4:0] idx,
                    input logic [15:0] d);
    @(negedge clock);
    cfgWr = '{inWrite: inW, outWrite: !inW, index: idx, data: d};
    @(negedge clock);
    cfgWr = '0;
  endtask
  task automatic rd(input logic [4:0] idx);
    @(negedge clock);
    rdIndex = idx;
    @(negedge clock);
  endtask
  task automatic pulse(input logic setNotClear);
    @(negedge clock);
    lockSet = setNotClear;
    lockClear = !setNotClear;
    @(negedge clock);
    lockSet = 1'b0;
    lockClear = 1'b0;
  endtask
  // ====================================================
  // Scenarios.
  task automatic testReset;
    rd(5'h00);
    cmp(outRdData, 16'h0000);
    cmp(inRdData, 16'h0000);
    cmp(pinOutEn, 26'h0);
    cmp(locked, 1'b0);
    $display("testReset done");
  endtask
  task automatic testOutMap;
    wr(1'b0, 5'h00, 16'hffff);
    rd(5'h00);
    cmp(outRdData, 16'h1f1f);
    wr(1'b0, 5'h00, 16'h0302);
    rd(5'h00);
    cmp(outRdData, 16'h0302);
    cmp(pinOutEn[1:0], 2'h3);
    cmp(pinOut[1:0], 2'h2);
    $display("testOutMap done");
  endtask
  task automatic testInMap;
    wr(1'b1, 5'h00, 16'h0001);
    wr(1'b1, 5'h03, 16'h0007);
    drivePin = 5'h07;
    repeat (6) @(negedge clock);
    cmp(periphIn[3], 1'b1);
    drivePin = 5'h08;
    repeat (6) @(negedge clock);
    cmp(periphIn[3], 1'b0);
    drivePin = 5'h01;
    repeat (6) @(negedge clock);
    cmp(periphIn[0], 1'b1);
    cmp(periphIn[3], 1'b0);
    rd(5'h03);
    cmp(inRdData, 16'h0007);
    rd(5'h00);
    cmp(outRdData, 16'h0302);
    cmp(inRdData, 16'h0001);
    $display("testInMap done");
  endtask
  task automatic testLock;
    pulse(1'b1);
    cmp(locked, 1'b1);
    wr(1'b0, 5'h00, 16'h0101);
    wr(1'b1, 5'h03, 16'h0001);
    wr(1'b1, 5'h00, 16'h0002);
    rd(5'h00);
    cmp(outRdData, 16'h0302);
    cmp(inRdData, 16'h0001);
    rd(5'h03);
    cmp(inRdData, 16'h0007);
    pulse(1'b0);
    cmp(locked, 1'b0);
    wr(1'b0, 5'h00, 16'h0101);
    rd(5'h00);
    cmp(outRdData, 16'h0101);
    $display("testLock done");
  endtask
  task automatic testMidReset;
    pulse(1'b1);
    @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    rd(5'h00);
    cmp(outRdData, 16'h0000);
    cmp(inRdData, 16'h0000);
    cmp(pinOutEn, 26'h0);
    cmp(pinOut, 26'h0);
    cmp(locked, 1'b0);
    $display("testMidReset done");
  endtask
  // ====================================================
  // Sequence, verdict and watchdog.
  task automatic endOfTest;
    $display("errCount=%0d checked=%0d", errCount, checked);
    if (errCount == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    testReset();
    testOutMap();
    testInMap();
    testLock();
    testMidReset();
    endOfTest();
  end
  initial begin
    #20000;
    errCount++;
    endOfTest();
  end
endmodule // ppr_remap_bench
`default_nettype wire
